//--- flash_pkg.sv
// Shared constants for the OTP area and four-wire read configuration logic
package flash_pkg;
  // ==========================================================
  // Opcodes
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_OTP_ERASE = 8'h44;
  localparam logic [7:0] OP_OTP_PROG = 8'h42;
  localparam logic [7:0] OP_OTP_READ = 8'h48;
  localparam logic [7:0] OP_SET_PARAM = 8'hC0;
  localparam logic [7:0] OP_FAST = 8'h0B;
  localparam logic [7:0] OP_QUAD_IO = 8'hEB;
  localparam logic [7:0] OP_WRAP_READ = 8'h0C;
  localparam logic [7:0] OP_BURST_CFG = 8'h77;
  localparam logic [7:0] OP_ENTER_4W = 8'h38;
  localparam logic [7:0] OP_EXIT_4W = 8'hFF;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  // ==========================================================
  // Geometry and field positions
  localparam int ADDR_W = 24;
  localparam int OTP_AW = 10;
  localparam int FIFO_W = 18;
  localparam int DUMMY_LO = 4;
  localparam int WRAP_LO = 0;
  localparam int BURST_WRAP_LO = 4;
  localparam logic [7:0] BLANK_BYTE = 8'hFF;
  // ==========================================================
  // Reset values and fixed counts
  localparam logic [1:0] DUMMY_RST = 2'h0;
  localparam logic [1:0] WRAP_RST = 2'h0;
  localparam logic [5:0] SYNC_RST = 6'h20;
  localparam logic [3:0] OTP_READ_DUMMY = 4'h8;
endpackage

//--- otp_store.sv
// Byte store for the three OTP areas and the program data FIFO
`timescale 1ns/1ns
`default_nettype none

module otp_byte_mem #(
  parameter int AW = 10
) (
  input wire logic core_clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:(1<<AW)-1];

  // Contents are non-volatile, so no reset here
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

module byte_fifo #(
  parameter int W = 18,
  parameter int DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [0:DEPTH-1];
  logic [PW-1:0] wp_q;
  logic [PW-1:0] rp_q;
  logic [PW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = cnt_q != (PW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem[rp_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == PW'(DEPTH-1)) ? '0 : wp_q + PW'(1);
      end
      if (pop) begin
        rp_q <= (rp_q == PW'(DEPTH-1)) ? '0 : rp_q + PW'(1);
      end
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

`default_nettype wire

//--- otp_qpi_cmd.sv
// Serial flash command logic: OTP areas, read parameters and four-wire mode
// Notes on behaviour
// - OTP erase ignored unless write latch was set earlier.
// - Three separately erasable and programmable 256-byte OTP areas.
// - Area chosen by address bits 15..12 = 1..3, others zero; else reads FFh.
// - Erase starts only if select rises right on a byte boundary.
// - Busy is 1 during self-timed erase; status reads still answered.
// - Write latch cleared when the erase cycle completes.
// - Locked area ignores all erase and program commands.
// - OTP program writes 1..256 bytes, only with write latch set.
// - OTP read is 48h, address, eight dummy clocks; inputs taken on rising edges.
// - Read data leaves on falling edges, most significant bit first.
// - Byte address wraps FFh to 00h within area until select rises.
// - Set read parameters accepted only in four-wire mode.
// - Parameter bits 5..4 pick 2, 4, 6 or 8 dummy clocks.
// - Parameter bits 1..0 pick 8, 16, 32 or 64 byte wrap.
// - Reset defaults are 8-byte wrap and 2 dummy clocks.
// - Programmed dummy count used only by 0Bh, EBh, 0Ch in four-wire mode.
// - In one-wire mode 77h bits 5..4 set wrap, kept into four-wire mode.
// - 0Ch reads like fast read, wrapping inside the aligned window.
// - 38h is the only entry to four-wire mode; ignored when quad bit is 0.
// - Power-up in one-wire mode; the two modes are never active together.
// - Entering four-wire mode keeps write latch and wrap length.
// - FFh returns to one-wire mode, keeping latch and wrap length.
// - 66h then 99h restores all volatile settings to defaults.
`timescale 1ns/1ns
`default_nettype none

module otp_qpi_cmd #(
  parameter int HOLD_CYCLES = 16,
  parameter int FIFO_DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  input wire logic quad_lines_allow_bit,
  input wire logic [2:0] otp_area_lock_bits,
  output logic [flash_pkg::ADDR_W-1:0] array_addr,
  input wire logic [7:0] array_rdata,
  output logic busy,
  output logic write_latch_flag,
  output logic four_wire_cmd_mode,
  output logic [1:0] dummy_count_field,
  output logic [1:0] wrap_size_field,
  output logic prog_drop
);
  import flash_pkg::*;

  typedef enum logic [2:0] {
    PH_OPC = 3'b000,
    PH_ADDR = 3'b001,
    PH_DUMMY = 3'b010,
    PH_DATA = 3'b011,
    PH_OUT = 3'b100,
    PH_SKIP = 3'b101
  } phase_t;

  typedef enum logic [1:0] {
    E_IDLE = 2'b00,
    E_ERASE = 2'b01,
    E_DRAIN = 2'b10,
    E_HOLD = 2'b11
  } engine_t;

  // ==========================================================
  // Pin synchronisers
  logic [5:0] s1_q;
  logic [5:0] s2_q;
  logic [5:0] s3_q;
  logic [5:0] st_q;
  logic [5:0] st_d;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_low;
  logic cs_rise;
  logic [3:0] io_now;

  // A pin counts as changed only once stages two and three agree
  assign st_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & st_q);
  assign sclk_rise = st_d[4] && !st_q[4];
  assign sclk_fall = !st_d[4] && st_q[4];
  assign cs_low = !st_d[5];
  assign cs_rise = st_d[5] && !st_q[5];
  assign io_now = st_d[3:0];

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
      s3_q <= SYNC_RST;
      st_q <= SYNC_RST;
    end else begin
      s1_q <= {cs_n, sclk, io_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Frame decode
  phase_t ph_q;
  phase_t ph_op;
  engine_t eng_q;
  logic qpi_q;
  logic wel_q;
  logic arm_q;
  logic [1:0] dummy_q;
  logic [1:0] wrap_q;
  logic [7:0] op_q;
  logic [7:0] sh_q;
  logic [7:0] sh_d;
  logic [2:0] bits_q;
  logic [3:0] bsum;
  logic [8:0] nbytes_q;
  logic [23:0] addr_q;
  logic [23:0] addr_d;
  logic [3:0] dcnt_q;
  logic [1:0] area_q;
  logic [1:0] area_d;
  logic hit_d;
  logic valid_q;
  logic ok_q;
  logic [7:0] prog_lo_q;
  logic rx;
  logic byte_done;
  logic addr_done;
  logic bound;
  logic live;

  assign rx = cs_low && sclk_rise;
  assign bsum = {1'b0, bits_q} + (qpi_q ? 4'h4 : 4'h1);
  assign byte_done = bsum[3];
  assign sh_d = qpi_q ? {sh_q[3:0], io_now} : {sh_q[6:0], io_now[0]};
  assign addr_d = qpi_q ? {addr_q[19:0], io_now} : {addr_q[22:0], io_now[0]};
  assign addr_done = rx && byte_done && ph_q == PH_ADDR && nbytes_q == 9'h003;
  assign hit_d = addr_d[23:16] == 8'h00 && addr_d[11:8] == 4'h0 &&
                 addr_d[15:14] == 2'b00 && addr_d[13:12] != 2'b00;
  assign area_d = addr_d[13:12] - 2'h1;
  assign bound = bits_q == 3'h0 && nbytes_q != 9'h000;
  assign live = cs_rise && bound && ph_q != PH_SKIP;

  always_comb begin
    ph_op = PH_DATA;
    if (eng_q != E_IDLE && sh_d != OP_RDSR) begin
      ph_op = PH_SKIP;
    end else begin
      unique case (sh_d)
        OP_RDSR: ph_op = PH_OUT;
        OP_OTP_ERASE, OP_OTP_PROG, OP_OTP_READ, OP_BURST_CFG: ph_op = qpi_q ? PH_SKIP : PH_ADDR;
        OP_FAST, OP_QUAD_IO, OP_WRAP_READ: ph_op = qpi_q ? PH_ADDR : PH_SKIP;
        OP_SET_PARAM: ph_op = qpi_q ? PH_DATA : PH_SKIP;
        default: ph_op = PH_DATA;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn || !cs_low) begin
      ph_q <= PH_OPC;
      bits_q <= 3'h0;
      nbytes_q <= 9'h000;
      dcnt_q <= 4'h0;
    end else if (rx) begin
      bits_q <= bsum[2:0];
      if (byte_done && nbytes_q != 9'h1FF) begin
        nbytes_q <= nbytes_q + 9'h001;
      end
      unique case (ph_q)
        PH_OPC: begin
          if (byte_done) begin
            ph_q <= ph_op;
          end
        end
        PH_ADDR: begin
          if (addr_done) begin
            if (op_q == OP_OTP_READ) begin
              ph_q <= PH_DUMMY;
              dcnt_q <= OTP_READ_DUMMY;
            end else if (op_q == OP_FAST || op_q == OP_QUAD_IO || op_q == OP_WRAP_READ) begin
              ph_q <= PH_DUMMY;
              dcnt_q <= {1'b0, dummy_q, 1'b0} + 4'h2;
            end else begin
              ph_q <= PH_DATA;
            end
          end
        end
        PH_DUMMY: begin
          dcnt_q <= dcnt_q - 4'h1;
          if (dcnt_q == 4'h1) begin
            ph_q <= PH_OUT;
          end
        end
        PH_DATA, PH_OUT, PH_SKIP: ph_q <= ph_q;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sh_q <= 8'h00;
      op_q <= 8'h00;
      addr_q <= 24'h000000;
      area_q <= 2'h0;
      valid_q <= 1'b0;
      ok_q <= 1'b0;
      prog_lo_q <= 8'h00;
    end else if (rx) begin
      sh_q <= sh_d;
      if (ph_q == PH_OPC && byte_done) begin
        op_q <= sh_d;
      end
      if (ph_q == PH_ADDR) begin
        addr_q <= addr_d;
      end
      if (addr_done) begin
        area_q <= area_d;
        valid_q <= hit_d;
        ok_q <= wel_q && hit_d && !otp_area_lock_bits[area_d];
        prog_lo_q <= addr_d[7:0];
      end
      if (byte_done && ph_q == PH_DATA && op_q == OP_OTP_PROG) begin
        prog_lo_q <= prog_lo_q + 8'h01;
      end
    end
  end

  // ==========================================================
  // Volatile settings
  logic soft_rst;
  logic eng_done;

  assign soft_rst = live && op_q == OP_RST && arm_q && nbytes_q == 9'h001;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      arm_q <= 1'b0;
    end else if (cs_rise && bound) begin
      arm_q <= live && op_q == OP_RST_EN && nbytes_q == 9'h001;
    end
  end

  // Mode switches leave the write latch and wrap length alone
  always_ff @(posedge core_clk) begin
    if (!resetn || soft_rst) begin
      qpi_q <= 1'b0;
      wel_q <= 1'b0;
      dummy_q <= DUMMY_RST;
      wrap_q <= WRAP_RST;
    end else begin
      if (eng_done) begin
        wel_q <= 1'b0;
      end
      if (live) begin
        unique case (op_q)
          OP_WREN: if (nbytes_q == 9'h001) wel_q <= 1'b1;
          OP_WRDI: if (nbytes_q == 9'h001) wel_q <= 1'b0;
          OP_ENTER_4W: if (nbytes_q == 9'h001 && !qpi_q && quad_lines_allow_bit) qpi_q <= 1'b1;
          OP_EXIT_4W: if (nbytes_q == 9'h001 && qpi_q) qpi_q <= 1'b0;
          OP_SET_PARAM: begin
            if (nbytes_q == 9'h002) begin
              dummy_q <= sh_q[DUMMY_LO +: 2];
              wrap_q <= sh_q[WRAP_LO +: 2];
            end
          end
          OP_BURST_CFG: if (nbytes_q == 9'h005) wrap_q <= sh_q[BURST_WRAP_LO +: 2];
          default: wel_q <= wel_q;
        endcase
      end
    end
  end

  // ==========================================================
  // Program FIFO, OTP store and self-timed engine
  logic push;
  logic in_ready;
  logic out_valid;
  logic out_ready;
  logic [FIFO_W-1:0] out_data;
  logic [7:0] ecnt_q;
  logic [15:0] hcnt_q;
  logic mem_we;
  logic [OTP_AW-1:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic [23:0] rd_q;
  logic start_erase;
  logic start_prog;

  // Bytes are written as they arrive; drain stalls only while an erase owns the port
  assign push = rx && byte_done && ph_q == PH_DATA && op_q == OP_OTP_PROG && ok_q;
  assign out_ready = eng_q != E_ERASE;
  assign mem_we = (eng_q == E_ERASE) || (out_valid && out_ready);
  assign mem_waddr = (eng_q == E_ERASE) ? {area_q, ecnt_q} : out_data[17:8];
  assign mem_wdata = (eng_q == E_ERASE) ? BLANK_BYTE : out_data[7:0];
  assign start_erase = live && op_q == OP_OTP_ERASE && nbytes_q == 9'h004 && ok_q;
  assign start_prog = cs_rise && ph_q == PH_DATA && op_q == OP_OTP_PROG && nbytes_q >= 9'h005 &&
                      ok_q;
  assign eng_done = eng_q == E_HOLD && hcnt_q == 16'h0001;
  assign busy = eng_q != E_IDLE;

  byte_fifo #(
    .W(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .resetn(resetn),
    .in_valid(push),
    .in_ready(in_ready),
    .in_data({area_q, prog_lo_q, sh_d}),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );

  otp_byte_mem #(
    .AW(OTP_AW)
  ) u_mem (
    .core_clk(core_clk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr({area_q, rd_q[7:0]}),
    .rdata(mem_rdata)
  );

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      prog_drop <= 1'b0;
    end else begin
      prog_drop <= push && !in_ready;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      eng_q <= E_IDLE;
      ecnt_q <= 8'h00;
      hcnt_q <= 16'h0000;
    end else begin
      unique case (eng_q)
        E_IDLE: begin
          ecnt_q <= 8'h00;
          if (start_erase) begin
            eng_q <= E_ERASE;
          end else if (start_prog) begin
            eng_q <= E_DRAIN;
          end
        end
        E_ERASE: begin
          ecnt_q <= ecnt_q + 8'h01;
          if (ecnt_q == 8'hFF) begin
            eng_q <= E_HOLD;
            hcnt_q <= 16'(HOLD_CYCLES);
          end
        end
        E_DRAIN: begin
          if (!out_valid) begin
            eng_q <= E_HOLD;
            hcnt_q <= 16'(HOLD_CYCLES);
          end
        end
        E_HOLD: begin
          hcnt_q <= hcnt_q - 16'h0001;
          if (hcnt_q == 16'h0001) begin
            eng_q <= E_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Read address stepping and output shifter
  logic [7:0] wmask;
  logic [23:0] rd_next;
  logic [7:0] src;
  logic [7:0] osh_q;
  logic [7:0] osh_d;
  logic [2:0] ocnt_q;
  logic [3:0] io_q;
  logic oen_q;
  logic load;

  assign wmask = 8'(8'h08 << wrap_q) - 8'h01;
  assign load = ocnt_q == 3'h0;

  always_comb begin
    rd_next = rd_q + 24'h000001;
    if (op_q == OP_OTP_READ) begin
      rd_next = {rd_q[23:8], rd_q[7:0] + 8'h01};
    end else if (op_q == OP_WRAP_READ) begin
      rd_next = {rd_q[23:8], (rd_q[7:0] & ~wmask) | ((rd_q[7:0] + 8'h01) & wmask)};
    end
    if (op_q == OP_RDSR) begin
      src = {6'h00, wel_q, busy};
    end else if (op_q == OP_OTP_READ) begin
      src = valid_q ? mem_rdata : BLANK_BYTE;
    end else begin
      src = array_rdata;
    end
    if (load) begin
      osh_d = src;
    end else begin
      osh_d = qpi_q ? {osh_q[3:0], 4'h0} : {osh_q[6:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rd_q <= 24'h000000;
    end else if (addr_done) begin
      rd_q <= addr_d;
    end else if (cs_low && sclk_fall && ph_q == PH_OUT && load) begin
      rd_q <= rd_next;
    end
  end

  // Old bits stay on the pins until the next falling edge, giving the host a full half period
  always_ff @(posedge core_clk) begin
    if (!resetn || !cs_low) begin
      osh_q <= 8'h00;
      ocnt_q <= 3'h0;
      io_q <= 4'h0;
      oen_q <= 1'b0;
    end else if (sclk_fall && ph_q == PH_OUT) begin
      osh_q <= osh_d;
      ocnt_q <= load ? (qpi_q ? 3'h1 : 3'h7) : ocnt_q - 3'h1;
      io_q <= qpi_q ? osh_d[7:4] : {2'b00, osh_d[7], 1'b0};
      oen_q <= 1'b1;
    end
  end

  assign io_out = io_q;
  assign io_oe = oen_q ? (qpi_q ? 4'hF : 4'h2) : 4'h0;
  assign array_addr = rd_q;
  assign write_latch_flag = wel_q;
  assign four_wire_cmd_mode = qpi_q;
  assign dummy_count_field = dummy_q;
  assign wrap_size_field = wrap_q;
endmodule

`default_nettype wire

//--- otp_qpi_cmd_properties.sv
// Concurrent checks on the ports of the OTP and four-wire command block
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Checker
module otp_qpi_cmd_properties #(
  parameter int HOLD_CYCLES = 16,
  parameter int FIFO_DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic quad_lines_allow_bit,
  input wire logic [3:0] io_oe,
  input wire logic busy,
  input wire logic write_latch_flag,
  input wire logic four_wire_cmd_mode,
  input wire logic [1:0] dummy_count_field,
  input wire logic [1:0] wrap_size_field,
  input wire logic prog_drop
);
  // Margin covers the FIFO tail of a program that ends right on a full queue
  localparam int BUSY_MAX = 256 + HOLD_CYCLES + FIFO_DEPTH + 8;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_pins_idle_released: assert property (cs_n [*8] |-> io_oe == 4'h0)
    else $error("Data pins driven with select high");
  a_oe_follows_mode: assert property (io_oe != 4'h0 |-> io_oe == (four_wire_cmd_mode ? 4'hF : 4'h2))
    else $error("Output enables disagree with the command mode");
  a_param_four_wire: assert property ($changed(dummy_count_field) |-> $past(four_wire_cmd_mode))
    else $error("Dummy count changed in one-wire mode");
  a_enter_needs_quad: assert property ($rose(four_wire_cmd_mode) |-> $past(quad_lines_allow_bit))
    else $error("Four-wire mode entered without the quad bit");
  a_enter_keeps_state: assert property ($rose(four_wire_cmd_mode) |-> $stable(wrap_size_field) && $stable(write_latch_flag))
    else $error("Mode entry disturbed wrap or latch");
  a_busy_needs_latch: assert property ($rose(busy) |-> $past(write_latch_flag) && cs_n)
    else $error("Busy started without latch or inside a frame");
  a_latch_not_busy: assert property ($rose(write_latch_flag) |-> !$past(busy))
    else $error("Latch set while busy");
  a_done_clears_latch: assert property ($fell(busy) |-> !write_latch_flag)
    else $error("Latch still set after the cycle ended");
  a_busy_bounded: assert property ($rose(busy) |-> busy [*2] ##[1:BUSY_MAX] !busy)
    else $error("Busy spell too short or never ended");
  a_wrap_between_frames: assert property ($changed(wrap_size_field) |-> cs_n)
    else $error("Wrap length changed inside a frame");
  a_no_prog_drop: assert property (!prog_drop)
    else $error("Program byte lost on a full queue");
endmodule

bind otp_qpi_cmd otp_qpi_cmd_properties #(
  .HOLD_CYCLES(HOLD_CYCLES),
  .FIFO_DEPTH(FIFO_DEPTH)
) u_props (
  .core_clk(core_clk),
  .resetn(resetn),
  .cs_n(cs_n),
  .quad_lines_allow_bit(quad_lines_allow_bit),
  .io_oe(io_oe),
  .busy(busy),
  .write_latch_flag(write_latch_flag),
  .four_wire_cmd_mode(four_wire_cmd_mode),
  .dummy_count_field(dummy_count_field),
  .wrap_size_field(wrap_size_field),
  .prog_drop(prog_drop)
);
`default_nettype wire

//--- flash_host_model.sv
// Behavioural host controller driving select, serial clock and data pins
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Host model
module flash_host_model (
  input wire logic core_clk,
  input wire logic [3:0] io_wire,
  output logic sclk,
  output logic cs_n,
  output logic [3:0] dout
);
  logic quad;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    dout = 4'h0;
    quad = 1'b0;
  end
  // Four core cycles per half gives the 400 ns link period
  task automatic half();
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  // Data moves while the clock is low; the device takes it on the rise
  task automatic put(input logic [7:0] b);
    for (int i = 7; i >= 0; i -= (quad ? 4 : 1)) begin
      dout = quad ? b[i -: 4] : {3'h0, b[i]};
      half();
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
  endtask
  // Released lines show the inverse, so a stale value never passes for data
  task automatic get(output logic [7:0] b);
    dout = ~dout;
    b = 8'h00;
    for (int i = 0; i < 8; i += (quad ? 4 : 1)) begin
      half();
      b = quad ? {b[3:0], io_wire} : {b[6:0], io_wire[1]};
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
  endtask
  // Select stays low for the whole frame and rises on a byte boundary
  task automatic start_frame(input logic [7:0] q[$]);
    cs_n = 1'b0;
    half();
    foreach (q[k])
      put(q[k]);
  endtask
  task automatic end_frame();
    half();
    cs_n = 1'b1;
    repeat (3) half();
  endtask
  task automatic cmd(input logic [7:0] q[$]);
    start_frame(q);
    end_frame();
  endtask
endmodule
`default_nettype wire

//--- test_flash_otp_regs_and_qpi_read_cfg.sv
// Self-checking bench for the OTP area and four-wire read configuration block
`timescale 1ns/1ns
`default_nettype none
`define CHECK(what, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("Error %s expected %h seen %h", what, exp, got); \
    end \
  end

// ==========================================================
// Bench
module test_flash_otp_regs_and_qpi_read_cfg;
  import flash_pkg::*;
  logic core_clk, resetn, quad_lines_allow_bit;
  logic [2:0] otp_area_lock_bits;
  wire logic sclk, cs_n, busy, write_latch_flag, four_wire_cmd_mode;
  wire logic [3:0] dout, io_in, io_out, io_oe;
  wire logic [ADDR_W-1:0] array_addr;
  wire logic [7:0] array_rdata;
  wire logic [1:0] dummy_count_field, wrap_size_field;
  int bad_count, n_checks, cycles;
  assign io_in = (io_oe & io_out) | (~io_oe & dout);
  // Array data follows the address so a stuck address shows
  assign array_rdata = array_addr[7:0] ^ 8'h5A;

  otp_qpi_cmd #(.HOLD_CYCLES(4), .FIFO_DEPTH(32)) dut (.core_clk(core_clk), .resetn(resetn),
    .sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .quad_lines_allow_bit(quad_lines_allow_bit), .otp_area_lock_bits(otp_area_lock_bits),
    .array_addr(array_addr), .array_rdata(array_rdata), .busy(busy),
    .write_latch_flag(write_latch_flag), .four_wire_cmd_mode(four_wire_cmd_mode),
    .dummy_count_field(dummy_count_field), .wrap_size_field(wrap_size_field), .prog_drop());
  flash_host_model host (.core_clk(core_clk), .io_wire(io_in), .sclk(sclk), .cs_n(cs_n),
    .dout(dout));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic wait_idle();
    for (int k = 0; k < 2000 && busy !== 1'b0; k++)
      @(posedge core_clk);
    #1;
    `CHECK("busy end", 1'b0, busy)
  endtask

  task automatic read_one(input logic [23:0] a, output logic [7:0] b);
    host.start_frame('{OP_OTP_READ, a[23:16], a[15:8], a[7:0], 8'h00});
    host.get(b);
    host.end_frame();
  endtask

  task automatic t_erase();
    logic [7:0] s;
    host.cmd('{OP_OTP_ERASE, 8'h00, 8'h10, 8'h00});
    `CHECK("busy no latch", 1'b0, busy)
    host.cmd('{OP_WREN});
    host.cmd('{OP_OTP_ERASE, 8'h00, 8'h10});
    `CHECK("busy short", 1'b0, busy)
    host.cmd('{OP_OTP_ERASE, 8'h00, 8'h10, 8'h00});
    host.start_frame('{OP_RDSR});
    host.get(s);
    host.end_frame();
    `CHECK("status busy", 8'h03, s)
    wait_idle();
    `CHECK("latch after erase", 1'b0, write_latch_flag)
    $display("Test erase done");
  endtask

  task automatic t_prog_read();
    logic [7:0] b;
    logic [7:0] exp [5] = '{8'hFF, 8'hA5, 8'h3C, 8'h96, 8'hFF};
    host.cmd('{OP_WREN});
    host.cmd('{OP_OTP_PROG, 8'h00, 8'h10, 8'hFE, 8'hA5, 8'h3C, 8'h96});
    wait_idle();
    host.start_frame('{OP_OTP_READ, 8'h00, 8'h10, 8'hFD, 8'h00});
    foreach (exp[k]) begin
      host.get(b);
      `CHECK("otp byte", exp[k], b)
    end
    host.end_frame();
    read_one(24'h001400, b);
    `CHECK("bad address", 8'hFF, b)
    $display("Test program and read done");
  endtask

  task automatic t_lock();
    otp_area_lock_bits = 3'h2;
    host.cmd('{OP_WREN});
    host.cmd('{OP_OTP_ERASE, 8'h00, 8'h20, 8'h00});
    `CHECK("busy locked erase", 1'b0, busy)
    host.cmd('{OP_OTP_PROG, 8'h00, 8'h20, 8'h00, 8'h11});
    `CHECK("busy locked program", 1'b0, busy)
    `CHECK("latch kept", 1'b1, write_latch_flag)
    otp_area_lock_bits = 3'h0;
    $display("Test lock done");
  endtask

  task automatic t_modes();
    host.cmd('{OP_SET_PARAM, 8'h30});
    `CHECK("dummy in one-wire", 2'h0, dummy_count_field)
    host.cmd('{OP_BURST_CFG, 8'h00, 8'h00, 8'h00, 8'h20});
    `CHECK("burst wrap", 2'h2, wrap_size_field)
    host.cmd('{OP_ENTER_4W});
    `CHECK("mode no quad", 1'b0, four_wire_cmd_mode)
    quad_lines_allow_bit = 1'b1;
    host.cmd('{OP_ENTER_4W});
    host.quad = 1'b1;
    `CHECK("mode entered", 1'b1, four_wire_cmd_mode)
    `CHECK("wrap kept", 2'h2, wrap_size_field)
    `CHECK("latch kept", 1'b1, write_latch_flag)
    for (int i = 0; i < 4; i++) begin
      host.cmd('{OP_SET_PARAM, {2'h0, 2'(3 - i), 2'h0, 2'(i)}});
      `CHECK("dummy code", 2'(3 - i), dummy_count_field)
      `CHECK("wrap code", 2'(i), wrap_size_field)
    end
    host.cmd('{OP_EXIT_4W});
    host.quad = 1'b0;
    `CHECK("mode left", 1'b0, four_wire_cmd_mode)
    `CHECK("wrap after exit", 2'h3, wrap_size_field)
    `CHECK("latch after exit", 1'b1, write_latch_flag)
    host.cmd('{OP_ENTER_4W});
    host.quad = 1'b1;
    host.cmd('{OP_SET_PARAM, 8'h30});
    host.cmd('{OP_RST_EN});
    host.cmd('{OP_RST});
    host.quad = 1'b0;
    `CHECK("dummy reset", 2'h0, dummy_count_field)
    `CHECK("wrap reset", 2'h0, wrap_size_field)
    `CHECK("mode reset", 1'b0, four_wire_cmd_mode)
    `CHECK("latch reset", 1'b0, write_latch_flag)
    $display("Test modes done");
  endtask

  task automatic t_wrap_read();
    logic [7:0] b;
    // Array bytes at 06h, 07h, then back to 00h, 01h of the 8-byte window
    logic [7:0] exp [4] = '{8'h5C, 8'h5D, 8'h5A, 8'h5B};
    host.cmd('{OP_ENTER_4W});
    host.quad = 1'b1;
    host.cmd('{OP_SET_PARAM, 8'h10});
    host.start_frame('{OP_WRAP_READ, 8'h00, 8'h01, 8'h06, 8'h00, 8'h00});
    foreach (exp[k]) begin
      host.get(b);
      `CHECK("wrap byte", exp[k], b)
    end
    host.end_frame();
    // The closing fall of the last byte already starts a fifth load
    `CHECK("wrap address", 24'h000103, array_addr)
    host.cmd('{OP_EXIT_4W});
    host.quad = 1'b0;
    $display("Test wrap read done");
  endtask

  initial begin
    resetn = 1'b0;
    quad_lines_allow_bit = 1'b0;
    otp_area_lock_bits = 3'h0;
    repeat (16) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    repeat (8) @(posedge core_clk);
    #1;
    `CHECK("dummy default", 2'h0, dummy_count_field)
    `CHECK("wrap default", 2'h0, wrap_size_field)
    `CHECK("mode default", 1'b0, four_wire_cmd_mode)
    $display("Test defaults done");
    t_erase();
    t_prog_read();
    t_lock();
    t_modes();
    t_wrap_read();
    print_verdict();
  end
endmodule
`default_nettype wire
